// >>> rtl/ptmd_pkg.sv
// Purpose: Constants and types for the six-channel PWM waveform core
// Assumes: APB word index = printed or chosen register index, byte address = 4 * index
// Notes:   Narrow registers sit in the low bits of the 32-bit data word
package ptmd_pkg;
  // Register indices
  localparam logic [7:0] IDX_CONTROL_ONE    = 8'hdf;
  localparam logic [7:0] IDX_DT_ENABLE      = 8'hf9;
  localparam logic [7:0] IDX_DT_COUNT_LOW   = 8'hfa;
  localparam logic [7:0] IDX_PERIOD_LOW     = 8'h10;
  localparam logic [7:0] IDX_PERIOD_HIGH    = 8'h11;
  localparam logic [7:0] IDX_RUN_CONTROL    = 8'h12;
  localparam logic [7:0] IDX_COUNTER_LOW    = 8'h13;
  localparam logic [7:0] IDX_COUNTER_HIGH   = 8'h14;
  localparam logic [7:0] IDX_TIMED_ACCESS   = 8'h15;
  localparam logic [7:0] IDX_DUTY_BASE      = 8'h20;
  localparam logic [7:0] IDX_DUTY_LAST      = 8'h2b;
  // Control register one fields
  localparam int         CTL_TYPE_BIT       = 4;
  localparam int         CTL_MODE_HI        = 7;
  localparam int         CTL_MODE_LO        = 6;
  localparam int         CTL_DIV_HI         = 2;
  // Dead-time enable register fields
  localparam int         DTE_COUNT_TOP_BIT  = 4;
  localparam logic [7:0] DTE_WRITE_MASK     = 8'h17;
  // Reset values
  localparam logic [7:0] RST_BYTE           = 8'h00;
  localparam logic [15:0] RST_WORD          = 16'h0000;
  // Timed-access unlock keys
  localparam logic [7:0] TA_KEY_FIRST       = 8'haa;
  localparam logic [7:0] TA_KEY_SECOND      = 8'h55;
  // Output mode codes
  localparam logic [1:0] MODE_INDEPENDENT   = 2'h0;
  localparam logic [1:0] MODE_COMPLEMENT    = 2'h1;
  localparam logic [1:0] MODE_SYNCHRONISED  = 2'h2;

  typedef enum logic [2:0] {
    TA_LOCKED = 3'h1,
    TA_ARMED  = 3'h2,
    TA_OPEN   = 3'h4
  } ptmd_ta_t;

  typedef struct packed {
    logic [1:0] mode;
    logic       centre;
    logic [2:0] div;
  } ptmd_cfg_t;
endpackage : ptmd_pkg

// >>> rtl/ptmd_core.sv
// Purpose: Six-channel PWM counter, duty compare, pair modes and dead-time insertion
// Assumes: APB slave, one clock, synchronous active-high reset
// Notes:   Counter steps once per divided tick; dead time counts in system clocks
// Behaviour
// - Control bit 4 picks edge-aligned (0) or centre-aligned (1) counting.
// - Edge-aligned: count up from zero to period, then restart at zero.
// - Edge-aligned: channel low on duty match, high when counter is zero.
// - Edge-aligned period lasts period plus one divided ticks.
// - Centre-aligned: count up to period, then down to zero, repeating.
// - Centre-aligned: low on up-count match, high on down-count match.
// - Centre-aligned period lasts twice the period value in ticks.
// - Mode field bits 7:6: independent, complementary, synchronised, reserved.
// - Independent mode after reset; each channel uses its own duty.
// - Complementary: odd channels invert even partner, own duty ignored.
// - Each pair has a 9-bit down-counter delaying rising edges until it reaches zero.
// - Enable bits 0,1,2 switch dead time for pairs 0/1, 2/3, 4/5.
// - Nine-bit count, top bit in enable bit 4; delay is count plus one clocks.
// - Dead time acts only in complementary mode.
// - Dead-time registers accept writes only after timed-access unlock.
// - Synchronised: odd channels copy their even partner in phase.
// - Each duty is a reset-zero high and low byte pair.
`timescale 1ns/1ps
module ptmd_core #(
  parameter int CHANNELS = 6,
  parameter int DT_WIDTH = 9
) (
  // Clock and control
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                ce,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // PWM channels
  output logic [CHANNELS-1:0]      pwm_out
);
  localparam int PAIRS = CHANNELS / 2;

  ptmd_pkg::ptmd_cfg_t        cfg;
  ptmd_pkg::ptmd_ta_t         ta_ff;
  logic [7:0]                 control_one_ff;
  logic [7:0]                 dt_enable_ff;
  logic [7:0]                 dt_count_low_ff;
  logic [15:0]                period_ff;
  logic                       run_ff;
  logic [15:0]                duty_ff [CHANNELS];
  logic [15:0]                cnt_ff;
  logic                       down_ff;
  logic [6:0]                 presc_ff;
  logic                       tick;
  logic [CHANNELS-1:0]        raw_ff;
  logic [CHANNELS-1:0]        shaped;
  logic [CHANNELS-1:0]        shaped_d_ff;
  logic [CHANNELS-1:0]        hold_ff;
  logic [CHANNELS-1:0]        pwm_out_ff;
  logic                       pready_ff;
  logic                       pslverr_ff;
  logic [31:0]                prdata_ff;
  logic                       access;
  logic                       wr_done;
  logic [7:0]                 idx;
  logic [7:0]                 wbyte;
  logic                       mapped;
  logic [31:0]                rdata;
  logic                       dt_mode;
  logic [DT_WIDTH-1:0]        dt_load;

  assign idx     = paddr[9:2];
  assign wbyte   = pwdata[7:0];
  assign access  = psel & penable & ~pready_ff;
  assign wr_done = psel & penable & pready_ff & pwrite & ~pslverr_ff;
  assign cfg.mode   = control_one_ff[ptmd_pkg::CTL_MODE_HI:ptmd_pkg::CTL_MODE_LO];
  assign cfg.centre = control_one_ff[ptmd_pkg::CTL_TYPE_BIT];
  assign cfg.div    = control_one_ff[ptmd_pkg::CTL_DIV_HI:0];
  assign dt_mode = (cfg.mode == ptmd_pkg::MODE_COMPLEMENT);
  assign dt_load = {dt_enable_ff[ptmd_pkg::DTE_COUNT_TOP_BIT], dt_count_low_ff};

  // APB handshake: one wait state, answer registered
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else if (ce) begin
      pready_ff  <= access;
      if (access) begin
        pslverr_ff <= ~mapped;
        prdata_ff  <= pwrite ? 32'h0000_0000 : rdata;
      end else begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  // Read decode
  always_comb begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    if (idx >= ptmd_pkg::IDX_DUTY_BASE && idx <= ptmd_pkg::IDX_DUTY_LAST) begin
      rdata[7:0] = idx[0] ? duty_ff[3'((idx - ptmd_pkg::IDX_DUTY_BASE) >> 1)][15:8]
                          : duty_ff[3'((idx - ptmd_pkg::IDX_DUTY_BASE) >> 1)][7:0];
    end else begin
      case (idx)
        ptmd_pkg::IDX_CONTROL_ONE:  rdata[7:0] = control_one_ff;
        ptmd_pkg::IDX_DT_ENABLE:    rdata[7:0] = dt_enable_ff;
        ptmd_pkg::IDX_DT_COUNT_LOW: rdata[7:0] = dt_count_low_ff;
        ptmd_pkg::IDX_PERIOD_LOW:   rdata[7:0] = period_ff[7:0];
        ptmd_pkg::IDX_PERIOD_HIGH:  rdata[7:0] = period_ff[15:8];
        ptmd_pkg::IDX_RUN_CONTROL:  rdata[7:0] = {7'h00, run_ff};
        ptmd_pkg::IDX_COUNTER_LOW:  rdata[7:0] = cnt_ff[7:0];
        ptmd_pkg::IDX_COUNTER_HIGH: rdata[7:0] = cnt_ff[15:8];
        ptmd_pkg::IDX_TIMED_ACCESS: rdata[7:0] = {7'h00, ta_ff == ptmd_pkg::TA_OPEN};
        default:                    mapped     = 1'b0;
      endcase
    end
  end

  // Timed access: key pair opens exactly one following write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ta_ff <= ptmd_pkg::TA_LOCKED;
    end else if (ce && wr_done) begin
      case (ta_ff)
        ptmd_pkg::TA_LOCKED: begin
          if (idx == ptmd_pkg::IDX_TIMED_ACCESS && wbyte == ptmd_pkg::TA_KEY_FIRST)
            ta_ff <= ptmd_pkg::TA_ARMED;
        end
        ptmd_pkg::TA_ARMED: begin
          if (idx == ptmd_pkg::IDX_TIMED_ACCESS && wbyte == ptmd_pkg::TA_KEY_SECOND)
            ta_ff <= ptmd_pkg::TA_OPEN;
          else
            ta_ff <= ptmd_pkg::TA_LOCKED;
        end
        ptmd_pkg::TA_OPEN:   ta_ff <= ptmd_pkg::TA_LOCKED;
        default:             ta_ff <= ptmd_pkg::TA_LOCKED;
      endcase
    end
  end

  // Control, period and dead-time registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      control_one_ff  <= ptmd_pkg::RST_BYTE;
      dt_enable_ff    <= ptmd_pkg::RST_BYTE;
      dt_count_low_ff <= ptmd_pkg::RST_BYTE;
      period_ff       <= ptmd_pkg::RST_WORD;
      run_ff          <= 1'b0;
    end else if (ce && wr_done) begin
      case (idx)
        ptmd_pkg::IDX_CONTROL_ONE:  control_one_ff  <= wbyte;
        ptmd_pkg::IDX_PERIOD_LOW:   period_ff[7:0]  <= wbyte;
        ptmd_pkg::IDX_PERIOD_HIGH:  period_ff[15:8] <= wbyte;
        ptmd_pkg::IDX_RUN_CONTROL:  run_ff          <= wbyte[0];
        ptmd_pkg::IDX_DT_ENABLE: begin
          if (ta_ff == ptmd_pkg::TA_OPEN)
            dt_enable_ff <= wbyte & ptmd_pkg::DTE_WRITE_MASK;
        end
        ptmd_pkg::IDX_DT_COUNT_LOW: begin
          if (ta_ff == ptmd_pkg::TA_OPEN)
            dt_count_low_ff <= wbyte;
        end
        default: ;
      endcase
    end
  end

  // Duty registers, low byte at even index
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < CHANNELS; i++)
        duty_ff[i] <= ptmd_pkg::RST_WORD;
    end else if (ce && wr_done && idx >= ptmd_pkg::IDX_DUTY_BASE
                 && idx <= ptmd_pkg::IDX_DUTY_LAST) begin
      if (idx[0])
        duty_ff[3'((idx - ptmd_pkg::IDX_DUTY_BASE) >> 1)][15:8] <= wbyte;
      else
        duty_ff[3'((idx - ptmd_pkg::IDX_DUTY_BASE) >> 1)][7:0] <= wbyte;
    end
  end

  // Prescaler: one tick every 2^div system clocks
  always_ff @(posedge clk_sys) begin
    // Stop clears only on an enabled clock, so a low ce still freezes everything
    if (rst || (ce && !run_ff))
      presc_ff <= 7'h00;
    else if (ce)
      presc_ff <= tick ? 7'h00 : presc_ff + 7'h01;
  end
  assign tick = run_ff && (presc_ff == 7'((7'h01 << cfg.div) - 7'h01));

  // Shared counter
  always_ff @(posedge clk_sys) begin
    if (rst || (ce && !run_ff)) begin
      cnt_ff  <= ptmd_pkg::RST_WORD;
      down_ff <= 1'b0;
    end else if (ce && tick) begin
      if (!cfg.centre) begin
        down_ff <= 1'b0;
        cnt_ff  <= (cnt_ff >= period_ff) ? 16'h0000 : cnt_ff + 16'h0001;
      end else if (!down_ff) begin
        if (cnt_ff >= period_ff && period_ff != 16'h0000) begin
          down_ff <= 1'b1;
          cnt_ff  <= period_ff - 16'h0001;
        end else if (cnt_ff < period_ff) begin
          cnt_ff  <= cnt_ff + 16'h0001;
        end
      end else begin
        cnt_ff <= cnt_ff - 16'h0001;
        if (cnt_ff == 16'h0001)
          down_ff <= 1'b0;
      end
    end
  end

  // Raw compare per channel and pair mode shaping
  generate
    for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          raw_ff[c] <= 1'b0;
        end else if (ce && tick) begin
          if (!cfg.centre) begin
            if (cnt_ff == duty_ff[c])
              raw_ff[c] <= 1'b0;
            else if (cnt_ff == 16'h0000)
              raw_ff[c] <= 1'b1;
          end else if (cnt_ff == duty_ff[c]) begin
            raw_ff[c] <= down_ff;
          end
        end
      end
      if (c % 2 == 0) begin : g_even
        assign shaped[c] = raw_ff[c];
      end else begin : g_odd
        always_comb begin
          case (cfg.mode)
            ptmd_pkg::MODE_COMPLEMENT:   shaped[c] = ~raw_ff[c-1];
            ptmd_pkg::MODE_SYNCHRONISED: shaped[c] = raw_ff[c-1];
            default:                     shaped[c] = raw_ff[c];
          endcase
        end
      end
    end
  endgenerate

  // Dead time per pair; a mid-run count change only affects the next rise
  generate
    for (genvar p = 0; p < PAIRS; p++) begin : g_pair
      logic [DT_WIDTH-1:0] dt_cnt_ff;
      logic [1:0]          rise;
      logic                dt_on;
      assign dt_on = dt_mode && dt_enable_ff[p];
      assign rise  = shaped[2*p+1:2*p] & ~shaped_d_ff[2*p+1:2*p];
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          dt_cnt_ff              <= '0;
          hold_ff[2*p+1:2*p]     <= 2'h0;
        end else if (ce) begin
          if (!dt_on) begin
            hold_ff[2*p+1:2*p] <= 2'h0;
          end else if (rise != 2'h0) begin
            dt_cnt_ff          <= dt_load;
            // Rise cycle is already one clock low, so a zero count holds no more
            hold_ff[2*p+1:2*p] <= (dt_load == '0) ? 2'h0 : rise;
          end else if (hold_ff[2*p+1:2*p] != 2'h0) begin
            dt_cnt_ff <= dt_cnt_ff - 1'b1;
            if (dt_cnt_ff == DT_WIDTH'(1))
              hold_ff[2*p+1:2*p] <= 2'h0;
            else
              hold_ff[2*p+1:2*p] <= hold_ff[2*p+1:2*p] & shaped[2*p+1:2*p];
          end
        end
      end
    end
  endgenerate

  // Output stage; rising edge held low while its pair counter runs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shaped_d_ff <= '0;
      pwm_out_ff  <= '0;
    end else if (ce) begin
      shaped_d_ff <= shaped;
      for (int k = 0; k < CHANNELS; k++) begin
        if (dt_mode && dt_enable_ff[k/2] && (hold_ff[k] ||
            (shaped[k] && !shaped_d_ff[k])))
          pwm_out_ff[k] <= 1'b0;
        else
          pwm_out_ff[k] <= shaped[k];
      end
    end
  end

  assign pready  = pready_ff;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;
  assign pwm_out = pwm_out_ff;
endmodule : ptmd_core

// >>> tb/ptmd_monitor.sv
// Purpose: Port-level checks for ptmd_core
// Assumes: no APB traffic while ce is low; output mode tracked from control writes
// Notes:   Pair checks wait 7 clocks after a mode write for the output pipe
`timescale 1ns/1ps
module ptmd_monitor #(
  parameter int CHANNELS = 6
) (
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                rst,
  // APB
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                pready,
  input wire logic [31:0]         prdata,
  input wire logic                pslverr,
  // Channels
  input wire logic [CHANNELS-1:0] pwm_out
);
  logic [1:0] mode_ff;
  logic [2:0] settle_ff;
  logic [7:0] idx;
  logic       mapped;
  logic       settled;
  logic       ctl_wr;
  assign idx = paddr[9:2];
  assign mapped = idx inside {ptmd_pkg::IDX_CONTROL_ONE, ptmd_pkg::IDX_DT_ENABLE,
    ptmd_pkg::IDX_DT_COUNT_LOW, [ptmd_pkg::IDX_PERIOD_LOW:ptmd_pkg::IDX_TIMED_ACCESS],
    [ptmd_pkg::IDX_DUTY_BASE:ptmd_pkg::IDX_DUTY_LAST]};
  assign settled = (settle_ff == 3'h7);
  assign ctl_wr = pready && psel && pwrite && (idx == ptmd_pkg::IDX_CONTROL_ONE);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_ff <= 2'h0;
    end else if (ctl_wr) begin
      mode_ff <= pwdata[7:6];
    end
  end
  // Settle time covers the raw and output register stages
  always_ff @(posedge clk_sys) begin
    if (rst || ctl_wr) begin
      settle_ff <= 3'h0;
    end else if (!settled) begin
      settle_ff <= settle_ff + 3'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_wait_one: assert property ($rose(penable) && psel |=> pready)
    else $error("ready not one wait state after access");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held two cycles");
  a_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
  a_setup_quiet: assert property (psel && !penable |-> !pready) else $error("ready in setup");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_err_unmapped: assert property (pready |-> pslverr == !mapped) else $error("error flag wrong");
  a_read_narrow: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_reset_low: assert property ($fell(rst) |-> pwm_out == '0)
    else $error("outputs not low after reset");
  a_comp_apart: assert property (
    mode_ff == ptmd_pkg::MODE_COMPLEMENT && settled |->
    !(pwm_out[0] && pwm_out[1]) && !(pwm_out[2] && pwm_out[3]) && !(pwm_out[4] && pwm_out[5]))
    else $error("complementary pair both high");
  a_sync_same: assert property (
    mode_ff == ptmd_pkg::MODE_SYNCHRONISED && settled |->
    pwm_out[1] == pwm_out[0] && pwm_out[3] == pwm_out[2] && pwm_out[5] == pwm_out[4])
    else $error("synchronised pair differs");
  c_err: cover property (pslverr);
  c_comp: cover property (mode_ff == ptmd_pkg::MODE_COMPLEMENT && settled && pwm_out[0]);
  c_sync: cover property (mode_ff == ptmd_pkg::MODE_SYNCHRONISED && settled && pwm_out[1]);
endmodule : ptmd_monitor

bind ptmd_core ptmd_monitor #(.CHANNELS(CHANNELS)) u_mon (.clk_sys(clk_sys), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .pwm_out(pwm_out));

// >>> tb/testbench.sv
// Purpose: Self-checking bench for ptmd_core
// Assumes: ce high except one freeze check; divider 0 except one divided check
// Notes:   High times are counted over whole periods, so phase does not matter
`timescale 1ns/1ps
module testbench;
  logic        clk_sys;
  logic        rst;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [5:0]  pwm_out;
  logic [31:0] rd;
  logic        er;
  int          errors;
  int          n_compared;
  int          hi [6];

  ptmd_core #(.CHANNELS(6), .DT_WIDTH(9)) dut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .pwm_out(pwm_out));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic close_out;
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Holds the request until ready is sampled high or 20 clocks pass
  task automatic apb(input logic [7:0] idx, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n < 20), 32'h1, "ready wait");
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string what);
    apb(idx, 1'b0, 8'h00);
    chk(rd, {24'h0, exp}, what);
  endtask : rdc

  task automatic ta_wr(input logic [7:0] idx, input logic [7:0] d);
    wr(ptmd_pkg::IDX_TIMED_ACCESS, ptmd_pkg::TA_KEY_FIRST);
    wr(ptmd_pkg::IDX_TIMED_ACCESS, ptmd_pkg::TA_KEY_SECOND);
    wr(idx, d);
  endtask : ta_wr

  task automatic measure(input int settle, input int n);
    repeat (settle) @(posedge clk_sys);
    foreach (hi[c]) hi[c] = 0;
    repeat (n) begin
      @(posedge clk_sys);
      foreach (hi[c]) hi[c] += int'(pwm_out[c] === 1'b1);
    end
  endtask : measure

  task automatic t_regs;
    rdc(ptmd_pkg::IDX_CONTROL_ONE, 8'h00, "control reset");
    for (int i = 0; i < 12; i++) rdc(ptmd_pkg::IDX_DUTY_BASE + 8'(i), 8'h00, "duty reset");
    wr(ptmd_pkg::IDX_DUTY_BASE + 8'h1, 8'h5a);
    rdc(ptmd_pkg::IDX_DUTY_BASE + 8'h1, 8'h5a, "duty readback");
    apb(8'h00, 1'b0, 8'h00);
    chk(32'(er), 32'h1, "unmapped error");
  endtask : t_regs

  task automatic t_edge;
    wr(ptmd_pkg::IDX_DUTY_BASE + 8'h1, 8'h00);
    wr(ptmd_pkg::IDX_PERIOD_LOW, 8'h09);
    wr(ptmd_pkg::IDX_DUTY_BASE, 8'h03);
    wr(ptmd_pkg::IDX_DUTY_BASE + 8'h2, 8'h05);
    wr(ptmd_pkg::IDX_DUTY_BASE + 8'h4, 8'h09);
    wr(ptmd_pkg::IDX_DUTY_BASE + 8'h8, 8'h07);
    wr(ptmd_pkg::IDX_RUN_CONTROL, 8'h01);
    rdc(ptmd_pkg::IDX_PERIOD_LOW, 8'h09, "period readback");
    measure(30, 20);
    chk(hi[0], 6, "edge ch0 high");
    chk(hi[1], 10, "edge ch1 high");
    chk(hi[2], 18, "edge ch2 high");
    chk(hi[3], 0, "edge ch3 high");
    chk(hi[4], 14, "edge ch4 high");
    chk(hi[5], 0, "edge ch5 high");
    wr(ptmd_pkg::IDX_CONTROL_ONE, 8'h01);
    measure(30, 40);
    chk(hi[0], 12, "divided ch0 high");
    wr(ptmd_pkg::IDX_CONTROL_ONE, 8'h00);
    // Outputs toggle within ten ticks unless ce really freezes the core
    @(posedge clk_sys);
    ce <= 1'b0;
    @(posedge clk_sys);
    rd = {26'h0, pwm_out};
    repeat (10) @(posedge clk_sys);
    chk({26'h0, pwm_out}, rd, "frozen outputs");
    ce <= 1'b1;
  endtask : t_edge

  task automatic t_centre;
    wr(ptmd_pkg::IDX_CONTROL_ONE, 8'h10);
    wr(ptmd_pkg::IDX_PERIOD_LOW, 8'h08);
    measure(40, 32);
    chk(hi[0], 12, "centre ch0 high");
    chk(hi[1], 20, "centre ch1 high");
    wr(ptmd_pkg::IDX_CONTROL_ONE, 8'h00);
    wr(ptmd_pkg::IDX_PERIOD_LOW, 8'h09);
  endtask : t_centre

  task automatic t_modes;
    int exp [4] = '{10, 14, 6, 10};
    int exp5 [4] = '{0, 6, 14, 0};
    for (int m = 0; m < 4; m++) begin
      wr(ptmd_pkg::IDX_CONTROL_ONE, {2'(m), 6'h00});
      measure(30, 20);
      chk(hi[1], exp[m], "mode ch1 high");
      chk(hi[0], 6, "mode ch0 high");
      chk(hi[5], exp5[m], "mode ch5 high");
    end
  endtask : t_modes

  // Dead time only changed while stopped
  task automatic t_dead;
    wr(ptmd_pkg::IDX_RUN_CONTROL, 8'h00);
    wr(ptmd_pkg::IDX_PERIOD_LOW, 8'h27);
    wr(ptmd_pkg::IDX_DUTY_BASE, 8'h14);
    wr(ptmd_pkg::IDX_DUTY_BASE + 8'h4, 8'h14);
    wr(ptmd_pkg::IDX_DT_COUNT_LOW, 8'h05);
    rdc(ptmd_pkg::IDX_DT_COUNT_LOW, 8'h00, "locked count");
    ta_wr(ptmd_pkg::IDX_DT_COUNT_LOW, 8'h05);
    rdc(ptmd_pkg::IDX_DT_COUNT_LOW, 8'h05, "unlocked count");
    ta_wr(ptmd_pkg::IDX_DT_ENABLE, 8'hff);
    rdc(ptmd_pkg::IDX_DT_ENABLE, 8'h17, "enable mask");
    ta_wr(ptmd_pkg::IDX_DT_ENABLE, 8'h11);
    wr(ptmd_pkg::IDX_CONTROL_ONE, 8'h40);
    wr(ptmd_pkg::IDX_RUN_CONTROL, 8'h01);
    measure(300, 40);
    chk(hi[0] + hi[1], 0, "long dead pair0");
    chk(hi[2], 20, "pair1 no dead");
    chk(hi[4], 7, "pair2 no dead");
    wr(ptmd_pkg::IDX_RUN_CONTROL, 8'h00);
    ta_wr(ptmd_pkg::IDX_DT_ENABLE, 8'h01);
    wr(ptmd_pkg::IDX_RUN_CONTROL, 8'h01);
    measure(80, 40);
    chk(hi[0], 14, "short dead ch0");
    chk(hi[1], 14, "short dead ch1");
    wr(ptmd_pkg::IDX_CONTROL_ONE, 8'h80);
    measure(40, 40);
    chk(hi[0], 20, "sync ch0 no dead");
    chk(hi[1], 20, "sync ch1 no dead");
  endtask : t_dead

  initial begin
    repeat (20000) @(posedge clk_sys);
    chk(32'h0, 32'h1, "watchdog");
    close_out();
  end

  initial begin
    {rst, ce, psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    ce = 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_edge();
    t_centre();
    t_modes();
    t_dead();
    close_out();
  end
endmodule : testbench
